// ===== logic/adc_irq_fault_power_cfg_regs.v
// interrupt, fault power-down, overload mute and power tune registers
`timescale 1ns/100ps
`include "adc_irq_fault_power_cfg_consts.vh"

// Summary of operation
// - ratio upper six bits read at bits 5..0 of ratio_detect_high.
// - ratio lower eight bits read at bits 7..0 of ratio_detect_low.
// - interrupt pin active low when polarity bit is 0, else high.
// - event mode 0 drives pin from unmasked latched events.
// - event mode 1 drives pin from unmasked live conditions.
// - mode 2 pulses 2 ms each 4 ms while unmasked latched event.
// - mode 3 gives one 2 ms pulse per unmasked event.
// - fault power-down select: none, unmasked, all; 3 reserved.
// - readback select 1 hides masked bits in latched register.
// - recovery bit 0 repowers after fault; 1 keeps channels down.
// - read clears latched bits with zero live; the clear-all select gives the same result, since live bits set again.
// - channel 1 muted in ADC1 overload recovery when bit 4 set.
// - channel 2 muted in ADC2 overload recovery when bit 3 set.
// - modulator clock halved when clock select bit is 1.
// - FIR decimation stage bypassed when bypass bit is 1.
// - element matching rate doubled when override bit is 1.
// - low-power filter enabled when its bit is 1.
// - reserved bits read zero; host writes only zero there.
module adc_irq_fault_power_cfg_regs #(
  parameter IRQ_PULSE_CYCLES = `IRQ_PULSE_MS * `SYS_CLK_KHZ,
  parameter IRQ_PERIOD_CYCLES = `IRQ_PERIOD_MS * `SYS_CLK_KHZ
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RESET,
  // control port register access
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output wire [7:0] REG_RDATA,
  // detected frame sync to clock source ratio
  input wire [13:0] RATIO_DETECTED,
  // interrupt and fault sources, mask bit 1 hides a source
  input wire [7:0] LIVE_STATUS,
  input wire [7:0] INT_MASK,
  // interrupt pin
  output wire IRQ_OUT,
  // fault power-down controls
  output wire [1:0] CH_POWER_DOWN,
  output wire BIAS_POWER_DOWN,
  // overload recovery and mutes
  input wire ADC1_OVERLOAD_RECOVERY,
  input wire ADC2_OVERLOAD_RECOVERY,
  output wire CH1_MUTE,
  output wire CH2_MUTE,
  // filter and power tuning controls
  output wire MODULATOR_CLOCK_HALVE,
  output wire COMB_ORDER_SELECT,
  output wire FIR_STAGE_BYPASS,
  output wire ELEMENT_MATCH_RATE_DOUBLE,
  output wire LOW_POWER_FILTER_ENABLE
);

  // configuration registers
  reg [7:0] interrupt_config_ff;
  reg [7:0] overload_mute_config_ff;
  reg [7:0] power_tune_config_ff;

  // read data
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;

  // fault power-down state
  reg [1:0] ch_pd_ff;
  reg [1:0] nxt_ch_pd;
  reg bias_pd_ff;
  reg nxt_bias_pd;

  // mute state
  reg ch1_mute_ff;
  reg ch2_mute_ff;

  // decoded fields
  wire irq_polarity;
  wire [1:0] irq_event_mode;
  wire [1:0] fault_powerdown_select;
  wire latch_readback_select;
  wire fault_recovery_select;
  wire latch_read_clear_select;

  // status paths
  wire [7:0] latched;
  wire [7:0] readback;
  wire new_event;
  wire latch_rd;
  wire [7:0] unmasked_live;
  wire [7:0] pd_faults;
  wire [1:0] ch_fault;
  wire bias_fault;

  // address match shared by read and write paths
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign irq_polarity = interrupt_config_ff[`IRQ_POLARITY_BIT];
  assign irq_event_mode = interrupt_config_ff[`IRQ_EVENT_HI:`IRQ_EVENT_LO];
  assign fault_powerdown_select =
    interrupt_config_ff[`FAULT_PD_HI:`FAULT_PD_LO];
  assign latch_readback_select = interrupt_config_ff[`LATCH_READBACK_BIT];
  assign fault_recovery_select = interrupt_config_ff[`FAULT_RECOVERY_BIT];
  assign latch_read_clear_select =
    interrupt_config_ff[`LATCH_READ_CLEAR_BIT];

  // register writes, reserved bits forced to zero
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      interrupt_config_ff <= `INTERRUPT_CONFIG_RESET;
    end else if (REG_WR && hit(REG_ADDR, `INTERRUPT_CONFIG_ADDR)) begin
      interrupt_config_ff <= REG_WDATA & `INTERRUPT_CONFIG_WMASK;
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      overload_mute_config_ff <= `OVERLOAD_MUTE_CONFIG_RESET;
    end else if (REG_WR && hit(REG_ADDR, `OVERLOAD_MUTE_CONFIG_ADDR)) begin
      overload_mute_config_ff <=
        REG_WDATA & `OVERLOAD_MUTE_CONFIG_WMASK;
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      power_tune_config_ff <= `POWER_TUNE_CONFIG_RESET;
    end else if (REG_WR && hit(REG_ADDR, `POWER_TUNE_CONFIG_ADDR)) begin
      power_tune_config_ff <=
        REG_WDATA & `POWER_TUNE_CONFIG_WMASK;
    end
  end

  // read data mux, unmapped addresses read zero
  always @* begin
    nxt_rdata = 8'h00;
    if (hit(REG_ADDR, `RATIO_DETECT_HIGH_ADDR)) begin
      nxt_rdata = {2'b00, RATIO_DETECTED[13:8]};
    end else if (hit(REG_ADDR, `RATIO_DETECT_LOW_ADDR)) begin
      nxt_rdata = RATIO_DETECTED[7:0];
    end else if (hit(REG_ADDR, `INTERRUPT_CONFIG_ADDR)) begin
      nxt_rdata = interrupt_config_ff;
    end else if (hit(REG_ADDR, `OVERLOAD_MUTE_CONFIG_ADDR)) begin
      nxt_rdata = overload_mute_config_ff;
    end else if (hit(REG_ADDR, `POWER_TUNE_CONFIG_ADDR)) begin
      nxt_rdata = power_tune_config_ff;
    end else if (hit(REG_ADDR, `LATCHED_STATUS_ADDR)) begin
      nxt_rdata = readback;
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rdata_ff <= 8'h00;
    end else if (REG_RD) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA = rdata_ff;

  // sticky status bank, cleared by a read of its address
  assign latch_rd = REG_RD && hit(REG_ADDR, `LATCHED_STATUS_ADDR);

  latched_status_bank u_latched (
    .clk(SYS_CLK),
    .rst(RESET),
    .live(LIVE_STATUS),
    .mask(INT_MASK),
    .readback_sel(latch_readback_select),
    .clear_any_sel(latch_read_clear_select),
    .rd_clear(latch_rd),
    .latched(latched),
    .readback(readback),
    .new_event(new_event)
  );

  // interrupt pin
  assign unmasked_live = LIVE_STATUS & ~INT_MASK;

  irq_signal_gen #(
    .PULSE_CYCLES(IRQ_PULSE_CYCLES),
    .PERIOD_CYCLES(IRQ_PERIOD_CYCLES)
  ) u_irq (
    .clk(SYS_CLK),
    .rst(RESET),
    .mode(irq_event_mode),
    .polarity(irq_polarity),
    .latched_any(|(latched & ~INT_MASK)),
    .live_any(|unmasked_live),
    .event_pulse(new_event),
    .irq_out(IRQ_OUT)
  );

  // fault sources chosen for power-down
  assign pd_faults =
    (fault_powerdown_select == `FAULT_PD_UNMASKED) ? unmasked_live :
    (fault_powerdown_select == `FAULT_PD_ALL) ? LIVE_STATUS :
    8'h00;

  // low nibble belongs to channel 1, high nibble to channel 2
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch_fault_gen
      assign ch_fault[g] = |pd_faults[4*g+3:4*g];
    end
  endgenerate

  assign bias_fault = |pd_faults;

  // auto recovery follows the fault, manual holds until the recovery bit clears or pd is deselected
  always @* begin
    nxt_ch_pd = ch_fault;
    nxt_bias_pd = bias_fault;
    if (fault_recovery_select &&
        fault_powerdown_select != `FAULT_PD_NONE) begin
      nxt_ch_pd = ch_pd_ff | ch_fault;
      nxt_bias_pd = bias_pd_ff | bias_fault;
    end
  end

  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ch_pd_ff <= 2'b00;
      bias_pd_ff <= 1'b0;
    end else begin
      ch_pd_ff <= nxt_ch_pd;
      bias_pd_ff <= nxt_bias_pd;
    end
  end

  assign CH_POWER_DOWN = ch_pd_ff;
  assign BIAS_POWER_DOWN = bias_pd_ff;

  // overload recovery mutes
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ch1_mute_ff <= 1'b0;
      ch2_mute_ff <= 1'b0;
    end else begin
      ch1_mute_ff <= overload_mute_config_ff[`CH1_OVERLOAD_MUTE_BIT] &&
                     ADC1_OVERLOAD_RECOVERY;
      ch2_mute_ff <= overload_mute_config_ff[`CH2_OVERLOAD_MUTE_BIT] &&
                     ADC2_OVERLOAD_RECOVERY;
    end
  end

  assign CH1_MUTE = ch1_mute_ff;
  assign CH2_MUTE = ch2_mute_ff;

  // filter and power tuning controls straight from the register
  assign MODULATOR_CLOCK_HALVE =
    power_tune_config_ff[`MOD_CLOCK_HALVE_BIT];
  assign COMB_ORDER_SELECT =
    power_tune_config_ff[`COMB_ORDER_BIT];
  assign FIR_STAGE_BYPASS =
    power_tune_config_ff[`FIR_BYPASS_BIT];
  assign ELEMENT_MATCH_RATE_DOUBLE =
    power_tune_config_ff[`ELEMENT_MATCH_RATE_BIT];
  assign LOW_POWER_FILTER_ENABLE =
    power_tune_config_ff[`LOW_POWER_FILTER_BIT];

endmodule

// ===== common/adc_irq_fault_power_cfg_consts.vh
// constants for the interrupt, fault and power tune register slice
`ifndef ADC_IRQ_FAULT_POWER_CFG_CONSTS_VH
`define ADC_IRQ_FAULT_POWER_CFG_CONSTS_VH

// register offsets
`define RATIO_DETECT_HIGH_ADDR 8'h40
`define RATIO_DETECT_LOW_ADDR 8'h41
`define INTERRUPT_CONFIG_ADDR 8'h42
`define OVERLOAD_MUTE_CONFIG_ADDR 8'h4b
`define POWER_TUNE_CONFIG_ADDR 8'h4e
`define LATCHED_STATUS_ADDR 8'h44

// reset values
`define INTERRUPT_CONFIG_RESET 8'h00
`define OVERLOAD_MUTE_CONFIG_RESET 8'h00
`define POWER_TUNE_CONFIG_RESET 8'h00
`define LATCHED_STATUS_RESET 8'h00

// writable bits, reserved bits stay zero
`define INTERRUPT_CONFIG_WMASK 8'hff
`define OVERLOAD_MUTE_CONFIG_WMASK 8'h18
`define POWER_TUNE_CONFIG_WMASK 8'hf4

// interrupt_config fields
`define IRQ_POLARITY_BIT 7
`define IRQ_EVENT_HI 6
`define IRQ_EVENT_LO 5
`define FAULT_PD_HI 4
`define FAULT_PD_LO 3
`define LATCH_READBACK_BIT 2
`define FAULT_RECOVERY_BIT 1
`define LATCH_READ_CLEAR_BIT 0

// overload_mute_config fields
`define CH1_OVERLOAD_MUTE_BIT 4
`define CH2_OVERLOAD_MUTE_BIT 3

// power_tune_config fields
`define MOD_CLOCK_HALVE_BIT 7
`define COMB_ORDER_BIT 6
`define FIR_BYPASS_BIT 5
`define ELEMENT_MATCH_RATE_BIT 4
`define LOW_POWER_FILTER_BIT 2

// interrupt event modes
`define IRQ_MODE_LATCHED 2'h0
`define IRQ_MODE_LIVE 2'h1
`define IRQ_MODE_REPEAT 2'h2
`define IRQ_MODE_ONE_SHOT 2'h3

// fault power-down selections
`define FAULT_PD_NONE 2'h0
`define FAULT_PD_UNMASKED 2'h1
`define FAULT_PD_ALL 2'h2

// timing
`define SYS_CLK_KHZ 20000
`define IRQ_PULSE_MS 2
`define IRQ_PERIOD_MS 4
`define IRQ_CNT_W 17

`endif

// ===== logic/latched_status_bank.v
// sticky interrupt status with clear-on-read and masked readback
`timescale 1ns/100ps
module latched_status_bank (
  // clock and reset
  input wire clk,
  input wire rst,
  // live conditions and mask, mask bit 1 hides a source
  input wire [7:0] live,
  input wire [7:0] mask,
  // configuration
  input wire readback_sel,
  input wire clear_any_sel,
  input wire rd_clear,
  // results
  output wire [7:0] latched,
  output wire [7:0] readback,
  output wire new_event
);

  reg [7:0] latch_ff;
  reg [7:0] nxt_latch;
  reg [7:0] clr_bits;
  reg event_ff;

  always @* begin
    clr_bits = 8'h00;
    if (rd_clear) begin
      clr_bits = clear_any_sel ? 8'hff : ~live;
    end
    nxt_latch = (latch_ff & ~clr_bits) | live;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_ff <= 8'h00;
      event_ff <= 1'b0;
    end else begin
      latch_ff <= nxt_latch;
      event_ff <= |(live & ~latch_ff & ~mask);
    end
  end

  assign latched = latch_ff;
  assign readback = readback_sel ? (latch_ff & ~mask) : latch_ff;
  assign new_event = event_ff;

endmodule

// ===== logic/irq_signal_gen.v
// interrupt pin shaping: latched, live, repeating and one-shot modes
`timescale 1ns/100ps
`include "adc_irq_fault_power_cfg_consts.vh"
module irq_signal_gen #(
  parameter PULSE_CYCLES = 40000,
  parameter PERIOD_CYCLES = 80000
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration
  input wire [1:0] mode,
  input wire polarity,
  // sources, already masked
  input wire latched_any,
  input wire live_any,
  input wire event_pulse,
  // pin level
  output wire irq_out
);

  reg [16:0] period_ff;
  reg [16:0] shot_ff;
  reg out_ff;
  reg active;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      period_ff <= 17'h00000;
    end else if (!latched_any || period_ff == PERIOD_CYCLES - 1) begin
      period_ff <= 17'h00000;
    end else begin
      period_ff <= period_ff + 17'h00001;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shot_ff <= 17'h00000;
    end else if (event_pulse) begin
      shot_ff <= PULSE_CYCLES[16:0];
    end else if (shot_ff != 17'h00000) begin
      shot_ff <= shot_ff - 17'h00001;
    end
  end

  always @* begin
    case (mode)
      `IRQ_MODE_LATCHED: active = latched_any;
      `IRQ_MODE_LIVE: active = live_any;
      `IRQ_MODE_REPEAT: active = latched_any &&
                                 (period_ff < PULSE_CYCLES);
      `IRQ_MODE_ONE_SHOT: active = (shot_ff != 17'h00000);
      default: active = 1'b0;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ff <= 1'b1;
    end else begin
      out_ff <= polarity ? active : ~active;
    end
  end

  assign irq_out = out_ff;

endmodule

// ===== sim/adc_regs_monitor.sv
// concurrent checks on the register slice ports
`timescale 1ns/100ps
module adc_regs_monitor #(
  parameter IRQ_PULSE_CYCLES = 40000,
  parameter IRQ_PERIOD_CYCLES = 80000
) (
  input wire SYS_CLK,
  input wire RESET,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire [13:0] RATIO_DETECTED,
  input wire [7:0] LIVE_STATUS,
  input wire [7:0] INT_MASK,
  input wire IRQ_OUT,
  input wire [1:0] CH_POWER_DOWN,
  input wire BIAS_POWER_DOWN,
  input wire ADC1_OVERLOAD_RECOVERY,
  input wire ADC2_OVERLOAD_RECOVERY,
  input wire CH1_MUTE,
  input wire CH2_MUTE,
  input wire MODULATOR_CLOCK_HALVE,
  input wire COMB_ORDER_SELECT,
  input wire FIR_STAGE_BYPASS,
  input wire ELEMENT_MATCH_RATE_DOUBLE,
  input wire LOW_POWER_FILTER_ENABLE
);
  reg [7:0] cfg_ff;
  reg [7:0] mute_ff;
  reg [17:0] act_ff;
  // pin active while in a pulsed mode
  wire act = (IRQ_OUT == cfg_ff[7]) && cfg_ff[6];
  always @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cfg_ff <= 8'h00;
      mute_ff <= 8'h00;
      act_ff <= 18'h00000;
    end else begin
      if (REG_WR && REG_ADDR == 8'h42) cfg_ff <= REG_WDATA;
      if (REG_WR && REG_ADDR == 8'h4b) mute_ff <= REG_WDATA;
      act_ff <= act ? act_ff + 18'h00001 : 18'h00000;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  AST_TUNE: assert property (
    REG_WR && REG_ADDR == 8'h4e |=> {MODULATOR_CLOCK_HALVE, COMB_ORDER_SELECT,
    FIR_STAGE_BYPASS, ELEMENT_MATCH_RATE_DOUBLE, LOW_POWER_FILTER_ENABLE} ==
    {$past(REG_WDATA[7:4]), $past(REG_WDATA[2])})
    else $error("tune outputs differ from written bits");
  AST_MUTE1: assert property (
    CH1_MUTE == $past(mute_ff[4] & ADC1_OVERLOAD_RECOVERY))
    else $error("channel 1 mute wrong");
  AST_MUTE2: assert property (
    CH2_MUTE == $past(mute_ff[3] & ADC2_OVERLOAD_RECOVERY))
    else $error("channel 2 mute wrong");
  AST_RATIO_HIGH: assert property (
    REG_RD && REG_ADDR == 8'h40 |=>
    REG_RDATA == {2'b00, $past(RATIO_DETECTED[13:8])})
    else $error("ratio upper read wrong");
  AST_IRQ_LIVE: assert property (
    $past(cfg_ff[6:5]) == 2'h1 && $stable(cfg_ff) |->
    IRQ_OUT == ($past(cfg_ff[7]) ~^ $past(|(LIVE_STATUS & ~INT_MASK))))
    else $error("live mode pin wrong");
  AST_IRQ_LATCHED: assert property (
    !$past(RESET, 2) && $past(|(LIVE_STATUS & ~INT_MASK), 2) &&
    $past(INT_MASK, 2) == $past(INT_MASK) && $past(cfg_ff[6:5]) == 2'h0 &&
    $stable(cfg_ff) |-> IRQ_OUT == cfg_ff[7])
    else $error("latched mode pin not active");
  AST_PULSE_LEN: assert property (
    act_ff <= IRQ_PULSE_CYCLES)
    else $error("pulse longer than allowed");
  AST_PD_ALL: assert property (
    $past(cfg_ff[4:3]) == 2'h2 && !$past(cfg_ff[1]) && $stable(cfg_ff) |->
    CH_POWER_DOWN == {|$past(LIVE_STATUS[7:4]), |$past(LIVE_STATUS[3:0])} &&
    BIAS_POWER_DOWN == |$past(LIVE_STATUS))
    else $error("fault power-down wrong");
  COV_REPEAT: cover property (cfg_ff[6:5] == 2'h2 && act);
  COV_PD: cover property (|CH_POWER_DOWN);
  COV_MUTE: cover property (CH1_MUTE || CH2_MUTE);
endmodule

bind adc_irq_fault_power_cfg_regs adc_regs_monitor #(
  .IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES), .IRQ_PERIOD_CYCLES(IRQ_PERIOD_CYCLES)
) u_adc_regs_monitor (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .RATIO_DETECTED(RATIO_DETECTED),
  .LIVE_STATUS(LIVE_STATUS), .INT_MASK(INT_MASK), .IRQ_OUT(IRQ_OUT),
  .CH_POWER_DOWN(CH_POWER_DOWN), .BIAS_POWER_DOWN(BIAS_POWER_DOWN),
  .ADC1_OVERLOAD_RECOVERY(ADC1_OVERLOAD_RECOVERY),
  .ADC2_OVERLOAD_RECOVERY(ADC2_OVERLOAD_RECOVERY),
  .CH1_MUTE(CH1_MUTE), .CH2_MUTE(CH2_MUTE),
  .MODULATOR_CLOCK_HALVE(MODULATOR_CLOCK_HALVE),
  .COMB_ORDER_SELECT(COMB_ORDER_SELECT), .FIR_STAGE_BYPASS(FIR_STAGE_BYPASS),
  .ELEMENT_MATCH_RATE_DOUBLE(ELEMENT_MATCH_RATE_DOUBLE),
  .LOW_POWER_FILTER_ENABLE(LOW_POWER_FILTER_ENABLE)
);

// ===== sim/host_model.sv
// host model driving the register port
`timescale 1ns/100ps
module host_model (
  // clock
  input wire clk,
  // register port
  output reg [7:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  output reg rd,
  input wire [7:0] rdata
);
  reg [7:0] hi;
  reg [7:0] lo;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task write_reg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~v;
    end
  endtask
  task read_reg(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge clk);
      v = rdata;
    end
  endtask
  // upper six bits above lower eight
  task read_ratio(output [13:0] r);
    begin
      read_reg(8'h40, hi);
      read_reg(8'h41, lo);
      r = {hi[5:0], lo};
    end
  endtask
endmodule

// ===== sim/tb.sv
// self-checking bench for the register slice
`timescale 1ns/100ps
module tb;
  reg clk, rst, ovl1, ovl2;
  reg [13:0] ratio;
  reg [7:0] live, mask, d;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd, irq, bias, mute1, mute2;
  wire [1:0] chpd;
  wire [4:0] tune;
  reg [13:0] r;
  reg [15:0] n;
  integer fails, tests_run;
  host_model u_host_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  adc_irq_fault_power_cfg_regs #(.IRQ_PULSE_CYCLES(4), .IRQ_PERIOD_CYCLES(8))
  u_adc_irq_fault_power_cfg_regs (.SYS_CLK(clk), .RESET(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .RATIO_DETECTED(ratio), .LIVE_STATUS(live),
    .INT_MASK(mask), .IRQ_OUT(irq), .CH_POWER_DOWN(chpd),
    .BIAS_POWER_DOWN(bias), .ADC1_OVERLOAD_RECOVERY(ovl1),
    .ADC2_OVERLOAD_RECOVERY(ovl2), .CH1_MUTE(mute1), .CH2_MUTE(mute2),
    .MODULATOR_CLOCK_HALVE(tune[4]), .COMB_ORDER_SELECT(tune[3]),
    .FIR_STAGE_BYPASS(tune[2]), .ELEMENT_MATCH_RATE_DOUBLE(tune[1]),
    .LOW_POWER_FILTER_ENABLE(tune[0]));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk_pin(input [15:0] g, input [15:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task chk_reg(input [7:0] a, input [7:0] e);
    begin
      u_host_model.read_reg(a, d);
      chk_pin({8'h00, d}, {8'h00, e});
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    u_host_model.write_reg(a, v);
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge clk);
  endtask
  task pulse_live(input [7:0] v);
    begin
      @(posedge clk) live <= v;
      @(posedge clk) live <= 8'h00;
    end
  endtask
  task count_active;
    begin
      n = 16'h0000;
      repeat (16) begin
        @(negedge clk);
        if (irq === 1'b0) n = n + 16'h0001;
      end
    end
  endtask
  task t_reset;
    begin
      chk_pin({irq, chpd, bias, mute1, mute2, tune}, 16'h0400);
      chk_reg(8'h42, 8'h00);
      chk_reg(8'h4b, 8'h00);
      chk_reg(8'h4e, 8'h00);
      chk_reg(8'h44, 8'h00);
      chk_reg(8'h7f, 8'h00);
    end
  endtask
  task t_ratio;
    begin
      @(posedge clk) ratio <= 14'h2abc;
      wr_reg(8'h40, 8'hff);
      u_host_model.read_ratio(r);
      chk_pin({2'b00, r}, 16'h2abc);
      chk_reg(8'h40, 8'h2a);
      chk_reg(8'h41, 8'hbc);
    end
  endtask
  task t_regs;
    begin
      wr_reg(8'h42, 8'hff);
      chk_reg(8'h42, 8'hff);
      wr_reg(8'h4b, 8'hff);
      chk_reg(8'h4b, 8'h18);
      wr_reg(8'h4e, 8'hff);
      chk_reg(8'h4e, 8'hf4);
      wr_reg(8'h4e, 8'ha4);
      cyc(1);
      chk_pin({11'h000, tune}, 16'h0015);
      wr_reg(8'h4e, 8'h50);
      cyc(1);
      chk_pin({11'h000, tune}, 16'h000a);
      wr_reg(8'h42, 8'h00);
    end
  endtask
  task t_mute;
    begin
      wr_reg(8'h4b, 8'h10);
      @(posedge clk) ovl1 <= 1'b1;
      ovl2 <= 1'b1;
      cyc(2);
      chk_pin({mute1, mute2}, 16'h0002);
      wr_reg(8'h4b, 8'h08);
      cyc(2);
      chk_pin({mute1, mute2}, 16'h0001);
    end
  endtask
  task t_latch;
    begin
      chk_reg(8'h44, 8'h00);
      pulse_live(8'h02);
      cyc(2);
      chk_pin(irq, 16'h0000);
      chk_reg(8'h44, 8'h02);
      chk_reg(8'h44, 8'h00);
      chk_pin(irq, 16'h0001);
      @(posedge clk) mask <= 8'h04;
      live <= 8'h04;
      wr_reg(8'h42, 8'h04);
      chk_reg(8'h44, 8'h00);
      chk_pin(irq, 16'h0001);
      wr_reg(8'h42, 8'h00);
      chk_reg(8'h44, 8'h04);
      chk_reg(8'h44, 8'h04);
      @(posedge clk) live <= 8'h00;
      mask <= 8'h00;
      chk_reg(8'h44, 8'h04);
      chk_reg(8'h44, 8'h00);
    end
  endtask
  task t_live;
    begin
      wr_reg(8'h42, 8'ha0);
      @(posedge clk) live <= 8'h01;
      cyc(2);
      chk_pin(irq, 16'h0001);
      @(posedge clk) mask <= 8'h01;
      cyc(2);
      chk_pin(irq, 16'h0000);
      @(posedge clk) live <= 8'h00;
      mask <= 8'h00;
      wr_reg(8'h42, 8'h00);
      chk_reg(8'h44, 8'h01);
    end
  endtask
  task t_pulsed(input [7:0] cfg, input [15:0] e);
    begin
      wr_reg(8'h42, cfg);
      pulse_live(8'h08);
      cyc(2);
      count_active;
      chk_pin(n, e);
      chk_reg(8'h44, 8'h08);
      cyc(3);
      chk_pin(irq, 16'h0001);
      wr_reg(8'h42, 8'h00);
    end
  endtask
  task t_fault;
    begin
      @(posedge clk) mask <= 8'h20;
      wr_reg(8'h42, 8'h10);
      @(posedge clk) live <= 8'h21;
      cyc(2);
      chk_pin({chpd, bias}, 16'h0007);
      wr_reg(8'h42, 8'h08);
      cyc(2);
      chk_pin({chpd, bias}, 16'h0003);
      wr_reg(8'h42, 8'h0a);
      @(posedge clk) live <= 8'h00;
      cyc(3);
      chk_pin({chpd, bias}, 16'h0003);
      wr_reg(8'h42, 8'h08);
      cyc(2);
      chk_pin({chpd, bias}, 16'h0000);
      @(posedge clk) mask <= 8'h00;
    end
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fails = fails + 1;
    close_out;
  end
  initial begin
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    ovl1 = 1'b0;
    ovl2 = 1'b0;
    ratio = 14'h0000;
    live = 8'h00;
    mask = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_ratio;
    t_regs;
    t_mute;
    t_latch;
    t_live;
    t_pulsed(8'h40, 16'h0008);
    t_pulsed(8'h60, 16'h0004);
    t_fault;
    close_out;
  end
endmodule
